// file: inc/cam_pkg.sv
package cam_pkg;

  // Array geometry.
  localparam int unsigned CAM_ENTRIES = 32;
  localparam int unsigned CAM_WIDTH   = 32;
  localparam int unsigned CAM_AW      = 5;
  localparam int unsigned CAM_LINES   = 16;

  // Register byte offsets on the bus.
  localparam logic [5:0] OFS_CTRL  = 6'h00;
  localparam logic [5:0] OFS_WDATA = 6'h04;
  localparam logic [5:0] OFS_WMASK = 6'h08;
  localparam logic [5:0] OFS_ADDR  = 6'h0C;
  localparam logic [5:0] OFS_CMD   = 6'h10;
  localparam logic [5:0] OFS_KEY   = 6'h14;
  localparam logic [5:0] OFS_STAT  = 6'h18;
  localparam logic [5:0] OFS_RES   = 6'h1C;
  localparam logic [5:0] OFS_HITS  = 6'h20;

  // Control fields: mode is two bits, the insertion field six bits.
  localparam int unsigned CTRL_MODE = 0;
  localparam int unsigned CTRL_OHOT = 2;
  localparam int unsigned CTRL_WCE  = 3;
  localparam int unsigned CTRL_RCE  = 4;
  localparam int unsigned CTRL_INS  = 8;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0018;

  // Insertion select bits inside the insertion field.
  localparam int unsigned INS_WD = 0;
  localparam int unsigned INS_WA = 1;
  localparam int unsigned INS_WE = 2;
  localparam int unsigned INS_RA = 3;
  localparam int unsigned INS_RE = 4;
  localparam int unsigned INS_RD = 5;

  // Command, address and status fields.
  localparam int unsigned CMD_WR     = 0;
  localparam int unsigned CMD_RD     = 1;
  localparam int unsigned ADDR_RA    = 8;
  localparam int unsigned STAT_BUSY  = 0;
  localparam int unsigned STAT_MATCH = 1;
  localparam int unsigned STAT_IDX   = 8;

  // Last cycle count of each timed step.
  localparam logic [1:0] WR_LAST      = 2'h1;
  localparam logic [1:0] WR_LAST_MASK = 2'h2;
  localparam logic [1:0] RD_LAST      = 2'h3;

  // Configuration image seed: entry i holds seed plus i.
  localparam logic [31:0] CAM_INIT_BASE = 32'h0000_0000;

  typedef enum logic [1:0] {MODE_CAM, MODE_RAM, MODE_ROM} cam_mode_t;

endpackage : cam_pkg

// file: src/cam_store.sv
`timescale 1ns/100ps
`default_nettype none
module cam_store #(
  parameter int unsigned ENTRIES   = 32,
  parameter int unsigned WIDTH     = 32,
  parameter int unsigned AW        = 5,
  parameter logic [31:0] INIT_BASE = 32'h0000_0000
) (
  // Clock and read-side clear.
  input  wire logic             clk,
  input  wire logic             rd_clr,
  // Write port.
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [WIDTH-1:0] wcare,
  // Read port.
  input  wire logic             re,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata_q,
  // Search port.
  input  wire logic [WIDTH-1:0] key,
  output logic      [ENTRIES-1:0] hit_vec
);

  logic [WIDTH-1:0] data_mem [ENTRIES];
  logic [WIDTH-1:0] care_mem [ENTRIES];
  logic [WIDTH-1:0] rdata_d;

  // Configuration image; every bit compares after load.
  initial begin
    for (int i = 0; i < ENTRIES; i++) begin
      data_mem[i] = WIDTH'(INIT_BASE) + WIDTH'(i);
      care_mem[i] = '1;
    end
  end

  // Data and care bits land together so no half-written entry can match.
  // A plain clocked process, because the configuration image also writes the array.
  always @(posedge clk) begin
    if (we) begin
      data_mem[waddr] <= wdata;
      care_mem[waddr] <= wcare;
    end
  end

  // Registered read port.
  always_comb begin
    rdata_d = re ? data_mem[raddr] : rdata_q;
  end

  always_ff @(posedge clk or posedge rd_clr) begin
    if (rd_clr) rdata_q <= '0;
    else rdata_q <= rdata_d;
  end

  // Every entry compares at once; a cleared care bit never blocks a hit.
  for (genvar g = 0; g < ENTRIES; g++) begin : g_cmp
    assign hit_vec[g] = ~|((data_mem[g] ^ key) & care_mem[g]);
  end

endmodule : cam_store
`default_nettype wire

// file: src/cam_top.sv
// The address map and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module cam_top #(
  parameter logic [31:0] INIT_BASE = cam_pkg::CAM_INIT_BASE
) (
  // Clock and clears.
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        clr_global,
  input  wire logic        clr_wr_local,
  input  wire logic        clr_rd_local,
  // Avalon-MM slave.
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Search results.
  output logic             match,
  output logic [cam_pkg::CAM_AW-1:0]    match_index,
  output logic [cam_pkg::CAM_LINES-1:0] hit_lines,
  output logic             hit_valid,
  output logic             hit_half
);
  import cam_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_WR, S_SRCH, S_OHLO, S_OHHI, S_RD, S_ACK} cam_state_t;

  logic              wr_clr, rd_clr, sel_cmd, sel_key, op_req, reg_wr, ohot, wce, rce;
  logic              dev_clr;
  logic [5:0]        ins;
  cam_mode_t         mode;
  logic [31:0]       ctrl_q, ctrl_d, wdata_q, wdata_d, wmask_q, wmask_d;
  logic [31:0]       addr_q, addr_d, key_q, key_d, rdat_q, rdat_d;
  logic              rd_pend_q, rd_pend_d;
  cam_state_t        st_q, st_d;
  logic [1:0]        cnt_q, cnt_d;
  logic              we_s, re_s;
  logic [31:0]       hit_q, hit_d, res_q, res_d, hit_vec;
  logic              match_q, match_d, hv_q, hv_d, half_q, half_d;
  logic [4:0]        idx_q, idx_d;
  logic [15:0]       lines_q, lines_d;
  logic [31:0]       wd_q, wd_d, wc_q, wc_d, rdo_q, rdo_d, mem_rd, rd_e, wd_e, wc_e;
  logic [4:0]        wa_q, wa_d, ra_q, ra_d, wa_e, ra_e;
  logic              we_q, we_d, re_q, re_d, mem_we, mem_re;

  // Write-side and read-side registers each have their own clear.
  assign wr_clr = sys_rst | clr_global | clr_wr_local;
  assign rd_clr = sys_rst | clr_global | clr_rd_local;
  assign dev_clr = sys_rst | clr_global;

  // Control field decode.
  assign mode = cam_mode_t'(ctrl_q[CTRL_MODE +: 2]);
  assign ohot = ctrl_q[CTRL_OHOT];
  assign wce  = ctrl_q[CTRL_WCE];
  assign rce  = ctrl_q[CTRL_RCE];
  assign ins  = ctrl_q[CTRL_INS +: 6];

  // Command and key writes are held by waitrequest until the step ends.
  assign sel_cmd = avs_address == OFS_CMD;
  assign sel_key = avs_address == OFS_KEY;
  assign op_req  = avs_write & (sel_cmd | sel_key);
  assign reg_wr  = avs_write & ~op_req;
  assign avs_waitrequest = op_req ? (st_q != S_ACK) : (avs_read & ~rd_pend_q);
  assign avs_readdata = rdat_q;

  // Byte-lane merge for writable registers.
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[8*b +: 8] = new_v[8*b +: 8];
    end
    return r;
  endfunction : be_merge

  // Lowest matching entry wins, so duplicates give a stable but partial answer.
  function automatic logic [4:0] first_hit(input logic [31:0] h);
    logic [4:0] r;
    r = '0;
    for (int i = CAM_ENTRIES - 1; i >= 0; i--) begin
      if (h[i]) r = 5'(i);
    end
    return r;
  endfunction : first_hit

  // Register file next values; reads take one wait cycle so data comes from a flop.
  always_comb begin
    logic [31:0] stat;
    stat = '0;
    stat[STAT_BUSY]      = st_q != S_IDLE;
    stat[STAT_MATCH]     = match_q;
    stat[STAT_IDX +: 5]  = idx_q;
    ctrl_d    = ctrl_q;
    wdata_d   = wdata_q;
    wmask_d   = wmask_q;
    addr_d    = addr_q;
    key_d     = key_q;
    rdat_d    = rdat_q;
    rd_pend_d = avs_read & ~rd_pend_q;
    if (reg_wr) begin
      case (avs_address)
        OFS_CTRL:  ctrl_d  = be_merge(ctrl_q, avs_writedata, avs_byteenable);
        OFS_WDATA: wdata_d = be_merge(wdata_q, avs_writedata, avs_byteenable);
        OFS_WMASK: wmask_d = be_merge(wmask_q, avs_writedata, avs_byteenable);
        OFS_ADDR:  addr_d  = be_merge(addr_q, avs_writedata, avs_byteenable);
        default: ;
      endcase
    end
    if (op_req && sel_key && st_q == S_IDLE) begin
      key_d = be_merge(key_q, avs_writedata, avs_byteenable);
    end
    if (avs_read && !rd_pend_q) begin
      case (avs_address)
        OFS_CTRL:  rdat_d = ctrl_q;
        OFS_WDATA: rdat_d = wdata_q;
        OFS_WMASK: rdat_d = wmask_q;
        OFS_ADDR:  rdat_d = addr_q;
        OFS_KEY:   rdat_d = key_q;
        OFS_STAT:  rdat_d = stat;
        OFS_RES:   rdat_d = res_q;
        OFS_HITS:  rdat_d = hit_q;
        default:   rdat_d = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge dev_clr) begin
    if (dev_clr) begin
      ctrl_q    <= CTRL_RST;
      wdata_q   <= '0;
      wmask_q   <= '0;
      addr_q    <= '0;
      key_q     <= '0;
      rdat_q    <= '0;
      rd_pend_q <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      wdata_q   <= wdata_d;
      wmask_q   <= wmask_d;
      addr_q    <= addr_d;
      key_q     <= key_d;
      rdat_q    <= rdat_d;
      rd_pend_q <= rd_pend_d;
    end
  end

  // Sequencer for writes, searches and memory reads.
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    we_s    = 1'b0;
    re_s    = 1'b0;
    hit_d   = hit_q;
    match_d = match_q;
    idx_d   = idx_q;
    res_d   = res_q;
    lines_d = lines_q;
    hv_d    = 1'b0;
    half_d  = half_q;
    case (st_q)
      S_IDLE: begin
        if (op_req) begin
          cnt_d = '0;
          st_d  = S_ACK;
          if (sel_key && mode == MODE_CAM) begin
            st_d = S_SRCH;
          end else if (sel_cmd && avs_writedata[CMD_WR] && mode != MODE_ROM) begin
            st_d = S_WR;
          end else if (sel_cmd && avs_writedata[CMD_RD] && mode != MODE_CAM) begin
            st_d = S_RD;
          end
        end
      end
      S_WR: begin
        cnt_d = cnt_q + 2'h1;
        if (cnt_q == ((wmask_q != '0) ? WR_LAST_MASK : WR_LAST)) begin
          we_s = 1'b1;
          st_d = S_ACK;
        end
      end
      S_SRCH: begin
        hit_d   = hit_vec;
        match_d = hit_vec != '0;
        idx_d   = first_hit(hit_vec);
        res_d   = {27'h0, first_hit(hit_vec)};
        st_d    = ohot ? S_OHLO : S_ACK;
      end
      S_OHLO: begin
        lines_d = hit_q[15:0];
        hv_d    = 1'b1;
        half_d  = 1'b0;
        st_d    = S_OHHI;
      end
      S_OHHI: begin
        lines_d = hit_q[31:16];
        hv_d    = 1'b1;
        half_d  = 1'b1;
        st_d    = S_ACK;
      end
      S_RD: begin
        re_s  = cnt_q == '0;
        cnt_d = cnt_q + 2'h1;
        if (cnt_q == RD_LAST) begin
          res_d = rd_e;
          st_d  = S_ACK;
        end
      end
      S_ACK:   st_d = S_IDLE;
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge dev_clr) begin
    if (dev_clr) begin
      st_q  <= S_IDLE;
      cnt_q <= '0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // Result side sits on the read-side clear.
  always_ff @(posedge sys_clk or posedge rd_clr) begin
    if (rd_clr) begin
      hit_q   <= '0;
      match_q <= 1'b0;
      idx_q   <= '0;
      res_q   <= '0;
      lines_q <= '0;
      hv_q    <= 1'b0;
      half_q  <= 1'b0;
    end else begin
      hit_q   <= hit_d;
      match_q <= match_d;
      idx_q   <= idx_d;
      res_q   <= res_d;
      lines_q <= lines_d;
      hv_q    <= hv_d;
      half_q  <= half_d;
    end
  end

  // Optional port registers; each side holds while its enable is low, so the two
  // sides advance independently even though they share one clock.
  always_comb begin
    wd_d  = wce ? wdata_q : wd_q;
    wc_d  = wce ? ~wmask_q : wc_q;
    wa_d  = wce ? addr_q[4:0] : wa_q;
    we_d  = wce ? we_s : we_q;
    ra_d  = rce ? addr_q[ADDR_RA +: 5] : ra_q;
    re_d  = rce ? re_s : re_q;
    rdo_d = rce ? mem_rd : rdo_q;
  end

  always_ff @(posedge sys_clk or posedge wr_clr) begin
    if (wr_clr) begin
      wd_q <= '0;
      wc_q <= '0;
      wa_q <= '0;
      we_q <= 1'b0;
    end else begin
      wd_q <= wd_d;
      wc_q <= wc_d;
      wa_q <= wa_d;
      we_q <= we_d;
    end
  end

  always_ff @(posedge sys_clk or posedge rd_clr) begin
    if (rd_clr) begin
      ra_q  <= '0;
      re_q  <= 1'b0;
      rdo_q <= '0;
    end else begin
      ra_q  <= ra_d;
      re_q  <= re_d;
      rdo_q <= rdo_d;
    end
  end

  // Bypass or registered path per port; the read wait covers the longest chain.
  assign wd_e   = ins[INS_WD] ? wd_q : wdata_q;
  assign wc_e   = ins[INS_WD] ? wc_q : ~wmask_q;
  assign wa_e   = ins[INS_WA] ? wa_q : addr_q[4:0];
  assign ra_e   = ins[INS_RA] ? ra_q : addr_q[ADDR_RA +: 5];
  assign rd_e   = ins[INS_RD] ? rdo_q : mem_rd;
  assign mem_we = (ins[INS_WE] ? we_q : we_s) & wce & (mode != MODE_ROM);
  assign mem_re = (ins[INS_RE] ? re_q : re_s) & rce;

  // Entry storage with parallel compare.
  cam_store #(
    .ENTRIES   (CAM_ENTRIES),
    .WIDTH     (CAM_WIDTH),
    .AW        (CAM_AW),
    .INIT_BASE (INIT_BASE)
  ) u_store (
    .clk     (sys_clk),
    .rd_clr  (rd_clr),
    .we      (mem_we),
    .waddr   (wa_e),
    .wdata   (wd_e),
    .wcare   (wc_e),
    .re      (mem_re),
    .raddr   (ra_e),
    .rdata_q (mem_rd),
    .key     (key_q),
    .hit_vec (hit_vec)
  );

  // Result outputs.
  assign match       = match_q;
  assign match_index = idx_q;
  assign hit_lines   = lines_q;
  assign hit_valid   = hv_q;
  assign hit_half    = half_q;

  // Checks on sequencing and results.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst || clr_global || clr_wr_local || clr_rd_local);

  sequence s_wr2;
    (st_q == S_WR) [*2] ##1 (st_q == S_ACK);
  endsequence
  sequence s_wr3;
    (st_q == S_WR) [*3] ##1 (st_q == S_ACK);
  endsequence

  a_wr_two_cyc: assert property (
    (st_q == S_IDLE && st_d == S_WR && wmask_q == '0) |=> s_wr2)
    else $error("Plain write did not take two cycles.");
  a_wr_mask_cyc: assert property (
    (st_q == S_IDLE && st_d == S_WR && wmask_q != '0) |=> s_wr3)
    else $error("Masked write did not take three cycles.");
  a_srch_parallel: assert property (
    (st_q == S_IDLE && st_d == S_SRCH) |=> (st_q == S_SRCH) ##1 (st_q inside {S_ACK, S_OHLO}))
    else $error("Search did not finish in one compare cycle.");
  a_match_flag: assert property (
    (st_q == S_SRCH) |=> (match == (hit_q != '0)))
    else $error("Match flag disagrees with the hit vector.");
  a_bin_index: assert property (
    (st_q == S_SRCH && !ohot) |=> (!match || (hit_q[match_index] && res_q[4:0] == match_index)))
    else $error("Binary result does not point at a hit.");
  a_onehot_halves: assert property (
    (st_q == S_SRCH && ohot) |-> ##2 (hit_valid && !hit_half && hit_lines == hit_q[15:0])
    ##1 (hit_valid && hit_half && hit_lines == hit_q[31:16]))
    else $error("One-hot halves out of order.");
  a_rom_locked: assert property (
    (mode == MODE_ROM) |-> !mem_we)
    else $error("Write reached the array in lookup mode.");
  a_ram_read: assert property (
    (st_q == S_IDLE && st_d == S_RD) |=> (st_q == S_RD) [*4] ##1 (st_q == S_ACK))
    else $error("Memory read did not complete in four cycles.");
  a_ack_release: assert property (
    (op_req && st_q == S_ACK) |-> !avs_waitrequest ##1 (st_q == S_IDLE))
    else $error("Held command was not released on completion.");

endmodule : cam_top
`default_nettype wire

// file: verif/cam_user.sv
`timescale 1ns/100ps
`default_nettype none
module cam_user (
  // Clock and slave answer.
  input  wire logic        clk,
  input  wire logic        waitreq,
  input  wire logic [31:0] rdata,
  // Request lines.
  output logic      [5:0]  addr,
  output logic             rd_o,
  output logic             wr_o,
  output logic      [31:0] wdata,
  output logic      [3:0]  be
);
  // The bus starts idle with all byte lanes enabled.
  initial begin
    addr  = 6'h3F;
    rd_o  = 1'b0;
    wr_o  = 1'b0;
    wdata = 32'h0000_0000;
    be    = 4'hF;
  end

  // One transfer; n counts the edges until waitrequest is seen low.
  task automatic xfer(input logic [5:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q, output int n);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_o  <= w;
    rd_o  <= !w;
    n = 0;
    // The request is held whole until the slave answers.
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0);
    q = rdata;
    wr_o  <= 1'b0;
    rd_o  <= 1'b0;
    // Released lines carry inverted values so stale data is never trusted.
    addr  <= ~a;
    wdata <= ~d;
  endtask : xfer
endmodule : cam_user
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_count++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
  import cam_pkg::*;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        clr_global = 1'b0;
  logic        clr_wr_local = 1'b0;
  logic        clr_rd_local = 1'b0;
  logic [5:0]  avs_address;
  logic        avs_read, avs_write, avs_waitrequest, match, hit_valid, hit_half;
  logic [31:0] avs_writedata, avs_readdata, q, r;
  logic [3:0]  avs_byteenable;
  logic [4:0]  match_index;
  logic [15:0] hit_lines, lo, hi;
  logic [31:0] m_d [32];
  logic [31:0] m_c [32];
  logic [31:0] s = 32'h0000_000C;
  logic [31:0] ctrl = CTRL_RST;
  int          err_count = 0;
  int          tests_run = 0;
  int          n, nh, chk_n = 1;

  // 100 MHz clock.
  always #5 sys_clk = ~sys_clk;

  cam_top uut (.sys_clk, .sys_rst, .clr_global, .clr_wr_local, .clr_rd_local,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .match, .match_index, .hit_lines,
    .hit_valid, .hit_half);

  cam_user u_usr (.clk(sys_clk), .waitreq(avs_waitrequest), .rdata(avs_readdata),
    .addr(avs_address), .rd_o(avs_read), .wr_o(avs_write), .wdata(avs_writedata),
    .be(avs_byteenable));

  // Gather both halves of a one-hot result mid-cycle, where they have settled.
  always @(negedge sys_clk) begin
    if (hit_valid === 1'b1) begin
      if (hit_half) hi = hit_lines;
      else lo = hit_lines;
      nh++;
    end
  end

  function automatic logic [31:0] xs();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  // Model hit vector: masked bits never block a match.
  function automatic logic [31:0] hv(input logic [31:0] k);
    logic [31:0] v;
    for (int i = 0; i < 32; i++) v[i] = ((k ^ m_d[i]) & m_c[i]) == 32'h0000_0000;
    return v;
  endfunction : hv

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    u_usr.xfer(a, 1'b1, d, q, n);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    u_usr.xfer(a, 1'b0, 32'h0000_0000, q, n);
    `CHK(q, e)
  endtask : rd

  task automatic setc(input logic [31:0] d);
    ctrl = d;
    wr(OFS_CTRL, d);
  endtask : setc

  // Entry write; only search and memory modes accept it.
  task automatic put(input int i, input logic [31:0] d, input logic [31:0] mk);
    logic ok;
    ok = ctrl[1:0] != 2'h2;
    wr(OFS_WDATA, d);
    wr(OFS_WMASK, mk);
    wr(OFS_ADDR, 32'(i));
    wr(OFS_CMD, 32'h0000_0001);
    if (chk_n) `CHK(n, !ok ? 2 : (mk != 0) ? 5 : 4)
    if (ok && ctrl[CTRL_WCE]) begin
      m_d[i] = d;
      m_c[i] = ~mk;
    end
  endtask : put

  task automatic rde(input int i);
    wr(OFS_ADDR, 32'(i) << 8);
    wr(OFS_CMD, 32'h0000_0002);
    if (chk_n) `CHK(n, 6)
    rd(OFS_RES, m_d[i]);
  endtask : rde

  task automatic srch(input logic [31:0] k);
    logic [31:0] v;
    int ix;
    v = hv(k);
    ix = 0;
    for (int i = 31; i >= 0; i--) if (v[i]) ix = i;
    nh = 0;
    wr(OFS_KEY, k);
    @(negedge sys_clk);
    if (chk_n) `CHK(n, ctrl[CTRL_OHOT] ? 5 : 3)
    `CHK(match, |v)
    if (ctrl[CTRL_OHOT]) begin
      `CHK(nh, 2)
      `CHK({hi, lo}, v)
    end else `CHK(match_index, ix[4:0])
    rd(OFS_HITS, v);
  endtask : srch

  // A read-side clear drops the results, a write-side clear leaves them;
  // a global clear or reset also restores control, so it is moved away first.
  task automatic pulse(input int k);
    if (k >= 2) setc(CTRL_RST | 32'h0000_0004);
    @(posedge sys_clk);
    case (k)
      0: clr_rd_local <= 1'b1;
      1: clr_wr_local <= 1'b1;
      2: clr_global <= 1'b1;
      default: sys_rst <= 1'b1;
    endcase
    @(posedge sys_clk);
    {clr_rd_local, clr_wr_local, clr_global, sys_rst} <= 4'h0;
    @(negedge sys_clk);
    `CHK(match, k == 1)
    if (k >= 2) begin
      ctrl = CTRL_RST;
      rd(OFS_CTRL, CTRL_RST);
    end
  endtask : pulse

  task automatic conclude();
    $display("Checks %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  // Hang guard, far beyond the expected run length.
  initial begin
    #200us;
    err_count++;
    conclude();
  end

  // Main sequence.
  initial begin
    for (int i = 0; i < 32; i++) begin
      m_d[i] = CAM_INIT_BASE + i;
      m_c[i] = '1;
    end
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(negedge sys_clk);
    `CHK(hit_valid, 1'b0)
    rd(OFS_CTRL, CTRL_RST);
    rd(6'h3C, 32'h0000_0000);
    rd(OFS_CMD, 32'h0000_0000);
    // Low five bits carry the index, so stored words never repeat.
    for (int i = 0; i < 8; i++) begin
      r = xs();
      put(i, {r[31:5], 5'(i)}, (i == 3) ? 32'h0000_FF00 : 32'h0000_0000);
    end
    for (int i = 0; i < 8; i++) srch(m_d[i] ^ ((i == 3) ? 32'h0000_A500 : 0));
    srch(32'h0000_0014);
    srch(xs());
    setc(CTRL_RST | 32'h0000_0004);
    put(9, m_d[2], 32'h0000_0000);
    srch(m_d[2]);
    srch(32'h0000_0014);
    srch(m_d[3] ^ 32'h0000_3300);
    setc(CTRL_RST | 32'h0000_0001);
    put(12, xs(), 32'h0000_0000);
    rde(12);
    rde(31);
    wr(OFS_KEY, 32'h0000_0001);
    `CHK(n, 2)
    setc(CTRL_RST | 32'h0000_0002);
    rde(5);
    put(5, xs(), 32'h0000_0000);
    rde(5);
    setc(32'h0000_0011);
    put(6, xs(), 32'h0000_0000);
    setc(32'h0000_0019);
    rde(6);
    chk_n = 0;
    setc(32'h0000_3F19);
    put(13, xs(), 32'h0000_0000);
    rde(13);
    setc(32'h0000_3F18);
    srch(m_d[13]);
    chk_n = 1;
    setc(CTRL_RST);
    for (int k = 0; k < 4; k++) begin
      srch(m_d[1]);
      pulse(k);
    end
    srch(m_d[4]);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
